/* verilog/rfis_top.sv */
// event status registers with read-to-clear, masks and request output
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "rfis_regs.svh"

module rfis_top
	import rfis_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_en,
	input wire logic osc_stable,
	input wire logic rx_active,
	input wire logic tx_active,
	input wire logic [9:0] fifo_count,
	input wire logic rx_start,
	input wire logic rx_end,
	input wire logic tx_done,
	input wire logic bit_collision,
	input wire logic emd_restart,
	input wire logic dcmd_done,
	input wire logic nrt_expired,
	input wire logic gpt_expired,
	input wire logic ext_field_on,
	input wire logic ext_field_off,
	input wire logic ca_collision,
	input wire logic ca_guard_done,
	input wire logic target_mode,
	input wire logic target_rate_found,
	input wire logic crc_err,
	input wire logic parity_err,
	input wire logic soft_framing_flag,
	input wire logic hard_framing_flag,
	input wire logic wake_timeout,
	input wire logic wake_every_timeout,
	input wire logic wake_amp_delta,
	input wire logic wake_phase_delta,
	input wire logic wake_cap_delta,
	output logic irq
);

	// ==========================================================
	// bus decode

	rfis_byte_t status_q [3];
	rfis_byte_t mask_q [3];
	rfis_byte_t set_v [3];
	rfis_byte_t clr_v [3];
	rfis_byte_t rd_byte;
	rfis_sel_e sel;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic setup;
	logic acc_done;
	logic osc_cond;
	logic osc_cond_q;
	logic lvl_cond;
	logic lvl_cond_q;
	logic any_pending;

	assign setup = psel & ~penable;
	assign acc_done = psel & penable & pready_q;

	always_comb begin
		case (paddr[7:2])
			`RFIS_IDX_MAIN: sel = RFIS_SEL_MAIN;
			`RFIS_IDX_TFE: sel = RFIS_SEL_TFE;
			`RFIS_IDX_ERW: sel = RFIS_SEL_ERW;
			`RFIS_IDX_MASK_MAIN: sel = RFIS_SEL_MASK_MAIN;
			`RFIS_IDX_MASK_TFE: sel = RFIS_SEL_MASK_TFE;
			`RFIS_IDX_MASK_ERW: sel = RFIS_SEL_MASK_ERW;
			default: sel = RFIS_SEL_NONE;
		endcase
		if (paddr[1:0] != 2'h0) begin
			sel = RFIS_SEL_NONE;
		end
	end

	always_comb begin
		case (sel)
			RFIS_SEL_MAIN: rd_byte = status_q[0];
			RFIS_SEL_TFE: rd_byte = status_q[1];
			RFIS_SEL_ERW: rd_byte = status_q[2];
			RFIS_SEL_MASK_MAIN: rd_byte = mask_q[0];
			RFIS_SEL_MASK_TFE: rd_byte = mask_q[1];
			RFIS_SEL_MASK_ERW: rd_byte = mask_q[2];
			default: rd_byte = 8'h00;
		endcase
	end

	// ==========================================================
	// bus answer
	// zero wait states: ready rises in the first access cycle

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else if (ce) begin
			pready_q <= setup;
		end
	end

	// read data is captured at setup, before the clear lands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (ce && setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else if (ce && setup) begin
			pslverr_q <= (sel == RFIS_SEL_NONE);
		end
	end

	// ==========================================================
	// event conditions

	// oscillator and fifo level are levels; flag only their rise
	assign osc_cond = osc_en & osc_stable;
	assign lvl_cond = (rx_active & (fifo_count > `RFIS_FIFO_RX_HI))
		| (tx_active & (fifo_count < `RFIS_FIFO_TX_LO));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cond_q <= 1'b0;
			lvl_cond_q <= 1'b0;
		end else if (ce) begin
			osc_cond_q <= osc_cond;
			lvl_cond_q <= lvl_cond;
		end
	end

	always_comb begin
		set_v[0] = 8'h00;
		set_v[0][`RFIS_B_OSC] = osc_cond & ~osc_cond_q;
		set_v[0][`RFIS_B_FIFO] = lvl_cond & ~lvl_cond_q;
		set_v[0][`RFIS_B_RXS] = rx_start;
		set_v[0][`RFIS_B_RXE] = rx_end;
		set_v[0][`RFIS_B_TXE] = tx_done;
		set_v[0][`RFIS_B_COL] = bit_collision;
		set_v[0][`RFIS_B_RST] = emd_restart;
		set_v[1] = 8'h00;
		set_v[1][`RFIS_B_DCT] = dcmd_done;
		set_v[1][`RFIS_B_NRT] = nrt_expired;
		set_v[1][`RFIS_B_GPT] = gpt_expired;
		set_v[1][`RFIS_B_EON] = ext_field_on;
		set_v[1][`RFIS_B_EOF] = ext_field_off;
		set_v[1][`RFIS_B_CAC] = ca_collision;
		set_v[1][`RFIS_B_CAT] = ca_guard_done;
		set_v[1][`RFIS_B_RATE] = target_mode & target_rate_found;
		set_v[2] = 8'h00;
		set_v[2][`RFIS_B_CRC] = crc_err;
		set_v[2][`RFIS_B_PAR] = parity_err;
		set_v[2][`RFIS_B_SOFT] = soft_framing_flag;
		set_v[2][`RFIS_B_HARD] = hard_framing_flag;
		set_v[2][`RFIS_B_WT] = wake_timeout & wake_every_timeout;
		set_v[2][`RFIS_B_WAM] = wake_amp_delta;
		set_v[2][`RFIS_B_WPH] = wake_phase_delta;
		set_v[2][`RFIS_B_WCAP] = wake_cap_delta;
	end

	// ==========================================================
	// status and mask registers

	always_comb begin
		clr_v[0] = {8{acc_done & ~pwrite & (sel == RFIS_SEL_MAIN)}};
		clr_v[1] = {8{acc_done & ~pwrite & (sel == RFIS_SEL_TFE)}};
		clr_v[2] = {8{acc_done & ~pwrite & (sel == RFIS_SEL_ERW)}};
	end

	for (genvar i = 0; i < 3; i++) begin : g_reg
		// the set term is or-ed after the clear so no event is lost
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				status_q[i] <= `RFIS_STATUS_RST;
			end else if (ce) begin
				status_q[i] <= (status_q[i] & ~clr_v[i]) | set_v[i];
			end
		end

		// masks only gate the request; status bits latch regardless
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mask_q[i] <= `RFIS_MASK_RST;
			end else if (ce && acc_done && pwrite
				&& sel == rfis_sel_e'(int'(RFIS_SEL_MASK_MAIN) + i)) begin
				mask_q[i] <= pwdata[7:0];
			end
		end
	end

	// ==========================================================
	// request output

	always_comb begin
		any_pending = 1'b0;
		for (int k = 0; k < 3; k++) begin
			any_pending = any_pending | (|(status_q[k] & ~mask_q[k]));
		end
	end

	// one cycle behind the status so the pin stays glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= any_pending;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	// ==========================================================
	// assertions

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence main_read;
		ce && acc_done && !pwrite && sel == RFIS_SEL_MAIN;
	endsequence

	sequence tfe_read;
		ce && acc_done && !pwrite && sel == RFIS_SEL_TFE;
	endsequence

	sequence erw_read;
		ce && acc_done && !pwrite && sel == RFIS_SEL_ERW;
	endsequence

	rd_clear_a: assert property (
		main_read and (ce && set_v[0] == 8'h00) |=> status_q[0] == 8'h00)
		else $error("main status not cleared by read");

	set_wins_a: assert property (
		tfe_read and (ce && set_v[1][`RFIS_B_CAC]) |=> status_q[1][`RFIS_B_CAC])
		else $error("event lost during clearing read");

	irq_level_a: assert property (
		ce ##1 1'b1 |-> irq_q == $past(any_pending))
		else $error("request output does not follow pending bits");

	mask_write_a: assert property (
		ce && acc_done && pwrite && sel == RFIS_SEL_MASK_ERW
		|=> mask_q[2] == $past(pwdata[7:0]))
		else $error("mask write not stored");

	osc_flag_a: assert property (
		ce && osc_en && osc_stable && !osc_cond_q
		|=> status_q[0][`RFIS_B_OSC])
		else $error("oscillator flag not set");

	fifo_rx_a: assert property (
		ce && rx_active && fifo_count == 10'h12d && !lvl_cond_q
		|=> status_q[0][`RFIS_B_FIFO])
		else $error("receive level flag not set");

	// at the boundary the condition itself must stay unarmed
	fifo_tx_a: assert property (
		ce && tx_active && !rx_active && fifo_count == 10'h0c8
		|-> !lvl_cond)
		else $error("transmit level armed at threshold");

	fifo_tx_set_a: assert property (
		ce && tx_active && fifo_count == 10'h0c7 && !lvl_cond_q
		|=> status_q[0][`RFIS_B_FIFO])
		else $error("transmit level flag not set");

	rsvd_zero_a: assert property (
		status_q[0][`RFIS_B_RSVD] == 1'b0)
		else $error("reserved main bit set");

	wake_opt_a: assert property (
		ce && wake_timeout && !wake_every_timeout
		&& !status_q[2][`RFIS_B_WT] |=> !status_q[2][`RFIS_B_WT])
		else $error("wake timer flag set without option");

	rate_gate_a: assert property (
		ce && !target_mode && !status_q[1][`RFIS_B_RATE]
		|=> !status_q[1][`RFIS_B_RATE])
		else $error("bit rate flag set outside target mode");

	ready_a: assert property (
		ce && setup ##1 ce |-> pready_q ##1 (!ce || !pready_q || setup))
		else $error("apb ready timing wrong");

	err_clear_a: assert property (
		erw_read and (ce && set_v[2] == 8'h00) |=> status_q[2] == 8'h00)
		else $error("error status not cleared by read");

	crc_latch_a: assert property (
		ce && crc_err |=> status_q[2][`RFIS_B_CRC])
		else $error("crc error flag not set");

	rx_start_a: assert property (
		ce && rx_start |=> status_q[0][`RFIS_B_RXS])
		else $error("receive start flag not set");

	ca_latch_a: assert property (
		ce && ca_collision |=> status_q[1][`RFIS_B_CAC])
		else $error("avoidance collision flag not set");

	guard_flag_a: assert property (
		ce && ca_guard_done |=> status_q[1][`RFIS_B_CAT])
		else $error("guard time flag not set");

	rate_set_a: assert property (
		ce && target_mode && target_rate_found
		|=> status_q[1][`RFIS_B_RATE])
		else $error("bit rate flag not set in target mode");

	// an unmasked pending error or wake-up bit must reach the pin one cycle later
	irq_raise_a: assert property (
		ce && (status_q[2] & ~mask_q[2]) != 8'h00 |=> irq_q)
		else $error("request not raised for pending error bit");

	slverr_a: assert property (
		ce && setup && sel == RFIS_SEL_NONE |=> pslverr_q)
		else $error("unmapped access not flagged");

	rd_data_a: assert property (
		ce && setup && !pwrite && sel == RFIS_SEL_MAIN
		|=> prdata_q[7:0] == $past(status_q[0]))
		else $error("read data not taken at setup");

	// with the enable low nothing may move, not even the request pin
	ce_freeze_a: assert property (
		!ce |=> status_q[0] == $past(status_q[0])
		&& status_q[1] == $past(status_q[1])
		&& status_q[2] == $past(status_q[2]) && irq_q == $past(irq_q))
		else $error("state moved while clock enable low");

endmodule

`default_nettype wire

/* verilog/rfis_regs.svh */
// register indices, bit positions and thresholds of the event status block
`ifndef RFIS_REGS_SVH
`define RFIS_REGS_SVH

// register indices; byte address is four times the index
`define RFIS_IDX_MASK_MAIN 6'h16
`define RFIS_IDX_MASK_TFE 6'h17
`define RFIS_IDX_MASK_ERW 6'h18
`define RFIS_IDX_MAIN 6'h1a
`define RFIS_IDX_TFE 6'h1b
`define RFIS_IDX_ERW 6'h1c

// main event status bits
`define RFIS_B_OSC 7
`define RFIS_B_FIFO 6
`define RFIS_B_RXS 5
`define RFIS_B_RXE 4
`define RFIS_B_TXE 3
`define RFIS_B_COL 2
`define RFIS_B_RST 1
`define RFIS_B_RSVD 0

// timer and field event status bits
`define RFIS_B_DCT 7
`define RFIS_B_NRT 6
`define RFIS_B_GPT 5
`define RFIS_B_EON 4
`define RFIS_B_EOF 3
`define RFIS_B_CAC 2
`define RFIS_B_CAT 1
`define RFIS_B_RATE 0

// error and wake-up event status bits
`define RFIS_B_CRC 7
`define RFIS_B_PAR 6
`define RFIS_B_SOFT 5
`define RFIS_B_HARD 4
`define RFIS_B_WT 3
`define RFIS_B_WAM 2
`define RFIS_B_WPH 1
`define RFIS_B_WCAP 0

`define RFIS_STATUS_RST 8'h00
`define RFIS_MASK_RST 8'h00
`define RFIS_FIFO_RX_HI 10'h12c
`define RFIS_FIFO_TX_LO 10'h0c8

`endif

/* verilog/rfis_pkg.sv */
// types shared by the event status block
`default_nettype none
package rfis_pkg;

	typedef logic [7:0] rfis_byte_t;

	typedef enum logic [2:0] {
		RFIS_SEL_NONE,
		RFIS_SEL_MAIN,
		RFIS_SEL_TFE,
		RFIS_SEL_ERW,
		RFIS_SEL_MASK_MAIN,
		RFIS_SEL_MASK_TFE,
		RFIS_SEL_MASK_ERW
	} rfis_sel_e;

endpackage
`default_nettype wire

/* verification/rfis_top_tb_top.sv */
// self-checking bench for the event status block
`timescale 1ns/1ns
`default_nettype none

module rfis_top_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, osc_en = 1'b0, osc_stable = 1'b0;
	logic rx_active = 1'b0, tx_active = 1'b0, target_mode = 1'b0;
	logic ce = 1'b1;
	logic wake_every_timeout = 1'b0, pready, pslverr, irq, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, d;
	logic [9:0] fifo_count = 10'h000;
	logic [20:0] ev = 21'h0;
	int failures = 0, compares = 0;

	always #50 pclk = ~pclk;

	rfis_top dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .osc_en, .osc_stable,
		.rx_active, .tx_active, .fifo_count, .rx_start(ev[0]),
		.rx_end(ev[1]), .tx_done(ev[2]), .bit_collision(ev[3]),
		.emd_restart(ev[4]), .dcmd_done(ev[5]), .nrt_expired(ev[6]),
		.gpt_expired(ev[7]), .ext_field_on(ev[8]), .ext_field_off(ev[9]),
		.ca_collision(ev[10]), .ca_guard_done(ev[11]), .target_mode,
		.target_rate_found(ev[12]), .crc_err(ev[13]), .parity_err(ev[14]),
		.soft_framing_flag(ev[15]), .hard_framing_flag(ev[16]),
		.wake_timeout(ev[17]), .wake_every_timeout, .wake_amp_delta(ev[18]),
		.wake_phase_delta(ev[19]), .wake_cap_delta(ev[20]), .irq);

	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// the master never assumes a latency: it waits for pready, bounded
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, d, e);
		chk(d, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, d, e);
	endtask

	task automatic pulse(input int i);
		@(posedge pclk);
		ev[i] <= 1'b1;
		@(posedge pclk);
		ev[i] <= 1'b0;
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset;
		for (int k = 0; k < 6; k++) begin
			rdc((k < 3 ? 8'h58 : 8'h5c) + 8'(4 * k), 32'h0);
		end
		chk(irq, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_events;
		logic [7:0] a;
		int b;
		target_mode <= 1'b1;
		wake_every_timeout <= 1'b1;
		for (int i = 0; i < 21; i++) begin
			if (i < 5) begin
				a = 8'h68;
				b = 5 - i;
			end else if (i < 13) begin
				a = 8'h6c;
				b = 12 - i;
			end else begin
				a = 8'h70;
				b = 20 - i;
			end
			if (i == 10) rdc(8'h6c, 32'h0);
			pulse(i);
			rdc(a, 32'h1 << b);
			rdc(a, 32'h0);
		end
		$display("test events done");
	endtask

	task automatic t_gates;
		target_mode <= 1'b0;
		wake_every_timeout <= 1'b0;
		pulse(12);
		pulse(17);
		rdc(8'h6c, 32'h0);
		rdc(8'h70, 32'h0);
		$display("test gates done");
	endtask

	// thresholds are checked on both sides of the boundary
	task automatic t_levels;
		osc_en <= 1'b1;
		rdc(8'h68, 32'h0);
		osc_stable <= 1'b1;
		repeat (2) @(posedge pclk);
		rdc(8'h68, 32'h80);
		rx_active <= 1'b1;
		fifo_count <= 10'h12c;
		repeat (2) @(posedge pclk);
		rdc(8'h68, 32'h0);
		fifo_count <= 10'h12d;
		repeat (2) @(posedge pclk);
		rdc(8'h68, 32'h40);
		rx_active <= 1'b0;
		tx_active <= 1'b1;
		fifo_count <= 10'h0c8;
		repeat (2) @(posedge pclk);
		rdc(8'h68, 32'h0);
		fifo_count <= 10'h0c7;
		repeat (2) @(posedge pclk);
		rdc(8'h68, 32'h40);
		$display("test levels done");
	endtask

	task automatic t_mask_irq;
		wr(8'h60, 32'h80);
		rdc(8'h60, 32'h80);
		pulse(13);
		repeat (3) @(posedge pclk);
		chk(irq, 32'h0);
		wr(8'h60, 32'h0);
		repeat (3) @(posedge pclk);
		chk(irq, 32'h1);
		rdc(8'h70, 32'h80);
		repeat (3) @(posedge pclk);
		chk(irq, 32'h0);
		$display("test mask done");
	endtask

	// event lands in the access cycle of the clearing read
	task automatic t_same_cycle;
		logic [31:0] rd;
		logic er;
		fork
			begin
				apb(1'b0, 8'h6c, 32'h0, rd, er);
				chk(rd, 32'h0);
			end
			begin
				repeat (2) @(posedge pclk);
				ev[5] <= 1'b1;
				@(posedge pclk);
				ev[5] <= 1'b0;
			end
		join
		rdc(8'h6c, 32'h80);
		apb(1'b0, 8'h04, 32'h0, rd, er);
		chk(rd, 32'h0);
		chk(er, 32'h1);
		$display("test same cycle done");
	endtask

	// an event offered while the enable is low is not taken
	task automatic t_freeze;
		ce <= 1'b0;
		pulse(13);
		repeat (2) @(posedge pclk);
		chk(irq, 32'h0);
		ce <= 1'b1;
		rdc(8'h70, 32'h0);
		$display("test freeze done");
	endtask

	// ==========================================
	// run control
	task automatic finish_test;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_events();
		t_gates();
		t_levels();
		t_mask_irq();
		t_same_cycle();
		t_freeze();
		finish_test();
	end

	// about 37 times the expected run length
	initial begin
		#1000000;
		failures++;
		finish_test();
	end
endmodule

`default_nettype wire
